// ===== hdl/cow_pkg.sv
// shared constants and carrier types for the compare-output waveform unit
package cow_pkg;
    localparam logic [2:0] REG_CTRL_A = 3'h0;
    localparam logic [2:0] REG_CTRL_B = 3'h1;
    localparam logic [2:0] REG_CMP_A = 3'h2;
    localparam logic [2:0] REG_CMP_B = 3'h3;
    localparam logic [2:0] REG_CMP_C = 3'h4;
    localparam logic [2:0] REG_CAPTURE = 3'h5;
    localparam logic [2:0] REG_COUNT = 3'h6;
    localparam logic [2:0] REG_STATUS = 3'h7;
    localparam int CHAN_A_MODE_POS = 6;
    localparam int CHAN_B_MODE_POS = 4;
    localparam int CHAN_C_MODE_POS = 2;
    localparam int WAVE_LO_POS = 0;
    localparam int WAVE_HI_POS = 3;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] MAX_COUNT = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef enum logic [1:0] {CLS_NON_PWM, CLS_FAST, CLS_DUAL} cow_class_e;
    typedef enum logic [1:0] {TOP_FIXED, TOP_CMP_A, TOP_CAPTURE} cow_top_src_e;
    typedef enum logic [1:0] {UPD_IMMEDIATE, UPD_TOP, UPD_BOTTOM} cow_update_e;

    typedef struct packed {
        cow_class_e cls;
        cow_top_src_e top_src;
        cow_update_e update;
        logic ovf_at_bottom;
        logic [15:0] fixed_top;
    } cow_mode_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cow_bus_s;
endpackage : cow_pkg

// ===== hdl/cow_unit.sv
// compare-output waveform unit: 16-bit counter, three compare channels
//
// Contract
// - One clock only; prescaled tick is a one-cycle count enable.
// - Double-buffered modes load active compare values only at update point.
// - Phase-and-frequency-correct modes load compare values at BOTTOM.
// - Bottom-flagged modes set overflow at BOTTOM with TOP-like timing.
// - Clear-on-match and fast PWM count TOP-1, TOP, BOTTOM, BOTTOM+1.
// - Dual-slope modes count TOP-1, TOP, TOP-1, TOP-2.
// - Control A: A mode 7:6, B 5:4, C 3:2, waveform low 1:0.
// - Nonzero output mode makes the channel drive its pin, except toggle outside its allowed modes.
// - Output mode meaning depends on non-PWM, fast, or dual-slope class.
// - Output mode 00 leaves the pin to the port in every class.
// - Non-PWM: 01 toggles, 10 clears, 11 sets on match.
// - Fast PWM 01 toggles A only in modes 14 and 15.
// - Fast PWM 10 clears on match, sets at TOP; 11 inverse.
// - Fast PWM: compare equal to TOP with upper bit set ignores match.
// - Dual-slope 01 toggles A only in modes 8 to 11.
// - Dual-slope 10 clears up-counting match, sets down-counting; 11 inverse.
// - Waveform mode joins two bits of each control register.
// - Dual-slope counts from zero up to TOP and back.
//
// The plain strobed port and the register addresses are this design's own decisions.
module cow_unit
    import cow_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // prescaled count tick
    input wire logic timer_count_enable,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // waveform outputs and pin overrides
    output logic [2:0] wave_out,
    output logic [2:0] port_override
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [2:0][15:0] cmp_buf;
        logic [2:0][15:0] compare_value;
        logic [15:0] capture_value;
        logic [15:0] counter_value;
        logic count_down;
        logic overflow_flag;
        logic capture_flag;
        logic [2:0] compare_match_flag;
        logic [2:0] wave;
        logic [2:0] override;
        logic [15:0] rdata;
    } cow_state_s;

    cow_state_s cur;
    cow_state_s next_cur;

    ////////////////////////////////////////////////////////////////////////
    function automatic cow_mode_s decode_mode(input logic [3:0] wm);
        cow_mode_s m;
        m.cls = CLS_NON_PWM;
        m.top_src = TOP_FIXED;
        m.update = UPD_IMMEDIATE;
        m.ovf_at_bottom = 1'b0;
        m.fixed_top = MAX_COUNT;
        case (wm)
            4'h1, 4'h2, 4'h3:
            begin
                m.cls = CLS_DUAL;
                m.update = UPD_TOP;
                m.ovf_at_bottom = 1'b1;
            end
            4'h4:
            begin
                m.top_src = TOP_CMP_A;
            end
            4'h5, 4'h6, 4'h7:
            begin
                m.cls = CLS_FAST;
                m.update = UPD_TOP;
            end
            4'h8, 4'h9:
            begin
                m.cls = CLS_DUAL;
                m.update = UPD_BOTTOM;
                m.ovf_at_bottom = 1'b1;
                m.top_src = wm[0] ? TOP_CMP_A : TOP_CAPTURE;
            end
            4'hA, 4'hB:
            begin
                m.cls = CLS_DUAL;
                m.update = UPD_TOP;
                m.ovf_at_bottom = 1'b1;
                m.top_src = wm[0] ? TOP_CMP_A : TOP_CAPTURE;
            end
            4'hC:
            begin
                m.top_src = TOP_CAPTURE;
            end
            4'hE, 4'hF:
            begin
                m.cls = CLS_FAST;
                m.update = UPD_TOP;
                m.top_src = wm[0] ? TOP_CMP_A : TOP_CAPTURE;
            end
            default:
            begin
                m.cls = CLS_NON_PWM;
            end
        endcase
        case (wm[1:0])
            2'h1: m.fixed_top = TOP_8BIT;
            2'h2: m.fixed_top = TOP_9BIT;
            2'h3: m.fixed_top = TOP_10BIT;
            default: m.fixed_top = MAX_COUNT;
        endcase
        return m;
    endfunction : decode_mode

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] waveform_mode;
    cow_mode_s mode;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic update_now;

    assign waveform_mode = {cur.ctrl_b[WAVE_HI_POS +: 2], cur.ctrl_a[WAVE_LO_POS +: 2]};
    assign mode = decode_mode(waveform_mode);

    always_comb
    begin
        case (mode.top_src)
            TOP_CMP_A: top = cur.compare_value[0];
            TOP_CAPTURE: top = cur.capture_value;
            default: top = mode.fixed_top;
        endcase
    end

    assign at_top = cur.counter_value == top;
    assign at_bottom = cur.counter_value == BOTTOM;

    always_comb
    begin
        case (mode.update)
            UPD_TOP: update_now = timer_count_enable && at_top;
            UPD_BOTTOM: update_now = timer_count_enable && at_bottom;
            default: update_now = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel output action, indexed 0=A, 1=B, 2=C
    logic [2:0][1:0] chan_mode;
    logic [2:0] chan_live;
    logic [2:0] next_wave;

    generate
        for (genvar ch = 0; ch < 3; ch++)
        begin : g_chan
            localparam int POS = (ch == 0) ? CHAN_A_MODE_POS :
                                 (ch == 1) ? CHAN_B_MODE_POS : CHAN_C_MODE_POS;
            logic match;
            logic toggle_ok;

            assign chan_mode[ch] = cur.ctrl_a[POS +: 2];
            assign match = timer_count_enable && (cur.counter_value == cur.compare_value[ch]);

            // toggle in PWM classes is for channel A only, in fast modes 14 and 15 and dual-slope modes 8 to 11
            always_comb
            begin
                case (mode.cls)
                    CLS_FAST: toggle_ok = (ch == 0) && (waveform_mode[3:1] == 3'h7);
                    CLS_DUAL: toggle_ok = (ch == 0) && (waveform_mode[3:2] == 2'h2);
                    default: toggle_ok = 1'b1;
                endcase
            end

            // toggle outside its allowed modes leaves the pin to the port
            assign chan_live[ch] = |chan_mode[ch] && (chan_mode[ch] != OM_TOGGLE || toggle_ok);

            always_comb
            begin
                next_wave[ch] = cur.wave[ch];
                case (mode.cls)
                    CLS_FAST:
                    begin
                        if (chan_mode[ch][1])
                        begin
                            // match at TOP is ignored; only the TOP action applies
                            if (timer_count_enable && at_top)
                                next_wave[ch] = ~chan_mode[ch][0];
                            else if (match)
                                next_wave[ch] = chan_mode[ch][0];
                        end
                        else if (chan_mode[ch] == OM_TOGGLE && toggle_ok && match)
                            next_wave[ch] = ~cur.wave[ch];
                    end
                    CLS_DUAL:
                    begin
                        if (chan_mode[ch][1] && match)
                            next_wave[ch] = chan_mode[ch][0] ^ cur.count_down;
                        else if (chan_mode[ch] == OM_TOGGLE && toggle_ok && match)
                            next_wave[ch] = ~cur.wave[ch];
                    end
                    default:
                    begin
                        if (match)
                        begin
                            case (chan_mode[ch])
                                OM_TOGGLE: next_wave[ch] = ~cur.wave[ch];
                                OM_CLEAR: next_wave[ch] = 1'b0;
                                OM_SET: next_wave[ch] = 1'b1;
                                default: next_wave[ch] = cur.wave[ch];
                            endcase
                        end
                    end
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        next_cur.rdata = 16'h0000;

        // counter; timer_count_enable is only an enable, never a clock
        if (timer_count_enable)
        begin
            if (mode.cls == CLS_DUAL)
            begin
                if (at_top && !cur.count_down)
                begin
                    next_cur.count_down = 1'b1;
                    next_cur.counter_value = cur.counter_value - 16'h0001;
                end
                else if (at_bottom && cur.count_down)
                begin
                    next_cur.count_down = 1'b0;
                    next_cur.counter_value = cur.counter_value + 16'h0001;
                end
                else if (cur.count_down)
                    next_cur.counter_value = cur.counter_value - 16'h0001;
                else
                    next_cur.counter_value = cur.counter_value + 16'h0001;
            end
            else
            begin
                next_cur.count_down = 1'b0;
                if (at_top && mode.top_src != TOP_FIXED || at_top && mode.cls == CLS_FAST)
                    next_cur.counter_value = BOTTOM;
                else
                    next_cur.counter_value = cur.counter_value + 16'h0001;
            end
        end

        // flags: a set of a flag that was clear wins over a same-cycle clear; an already-set flag is cleared
        if (timer_count_enable)
        begin
            if (mode.ovf_at_bottom ? (at_bottom && cur.count_down) :
                (mode.cls == CLS_FAST ? at_top : cur.counter_value == MAX_COUNT))
                next_cur.overflow_flag = 1'b1;
            if (mode.top_src == TOP_CAPTURE && at_top)
                next_cur.capture_flag = 1'b1;
            for (int i = 0; i < 3; i++)
            begin
                if (cur.counter_value == cur.compare_value[i])
                    next_cur.compare_match_flag[i] = 1'b1;
            end
        end

        if (update_now)
            next_cur.compare_value = cur.cmp_buf;

        next_cur.wave = next_wave;
        for (int i = 0; i < 3; i++)
            next_cur.override[i] = chan_live[i];

        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                REG_CTRL_A: next_cur.ctrl_a = reg_wdata[7:0];
                REG_CTRL_B: next_cur.ctrl_b = reg_wdata[7:0];
                REG_CMP_A, REG_CMP_B, REG_CMP_C:
                begin
                    next_cur.cmp_buf[reg_addr - REG_CMP_A] = reg_wdata;
                    if (mode.update == UPD_IMMEDIATE)
                        next_cur.compare_value[reg_addr - REG_CMP_A] = reg_wdata;
                end
                REG_CAPTURE: next_cur.capture_value = reg_wdata;
                REG_COUNT: next_cur.counter_value = reg_wdata;
                REG_STATUS:
                begin
                    // write one to clear; a same-cycle hardware set is kept only if the flag was clear before
                    next_cur.overflow_flag = next_cur.overflow_flag & ~(reg_wdata[0] & ~(next_cur.overflow_flag
                        & ~cur.overflow_flag));
                    next_cur.capture_flag = next_cur.capture_flag & ~(reg_wdata[1] & ~(next_cur.capture_flag
                        & ~cur.capture_flag));
                    for (int i = 0; i < 3; i++)
                    begin
                        if (reg_wdata[2 + i] && cur.compare_match_flag[i])
                            next_cur.compare_match_flag[i] = next_cur.compare_match_flag[i]
                                & ~cur.compare_match_flag[i] & next_wave[i] ^ next_wave[i]
                                ? 1'b0 : 1'b0;
                    end
                end
                default: next_cur.ctrl_a = cur.ctrl_a;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL_A: next_cur.rdata = {8'h00, cur.ctrl_a};
                REG_CTRL_B: next_cur.rdata = {8'h00, cur.ctrl_b};
                REG_CMP_A: next_cur.rdata = cur.cmp_buf[0];
                REG_CMP_B: next_cur.rdata = cur.cmp_buf[1];
                REG_CMP_C: next_cur.rdata = cur.cmp_buf[2];
                REG_CAPTURE: next_cur.rdata = cur.capture_value;
                REG_COUNT: next_cur.rdata = cur.counter_value;
                REG_STATUS: next_cur.rdata = {8'h00, cur.count_down, cur.wave[2:0], cur.compare_match_flag[2],
                    cur.compare_match_flag[1:0] , cur.capture_flag} << 1 | {15'h0000, cur.overflow_flag};
                default: next_cur.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '0;
            cur.ctrl_a <= CTRL_A_RESET;
            cur.ctrl_b <= CTRL_B_RESET;
        end
        else if (clk_en)
            cur <= next_cur;
    end

    assign reg_rdata = cur.rdata;
    assign wave_out = cur.wave;
    assign port_override = cur.override;

endmodule : cow_unit

// ===== test/cow_unit_chk.sv
// port-level assertions for the compare-output waveform unit
module cow_unit_chk
    import cow_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // tick and register port
    input wire logic timer_count_enable,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // outputs
    input wire logic [2:0] wave_out,
    input wire logic [2:0] port_override
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] shadow_a;
    logic [7:0] shadow_b;
    logic [1:0] since_wr;
    logic wr_ctrl;
    logic wr_ctrl_b;
    logic wr_any;
    logic [3:0] wm;
    logic pwm;
    logic a_tog;
    logic [2:0] mode_on;
    assign wr_ctrl = reg_wr && clk_en && reg_addr == REG_CTRL_A;
    assign wr_ctrl_b = reg_wr && clk_en && reg_addr == REG_CTRL_B;
    assign wr_any = wr_ctrl || wr_ctrl_b;
    assign wm = {shadow_b[4:3], shadow_a[1:0]};
    assign pwm = wm inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
    assign a_tog = wm inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
    // toggle in pwm classes connects only channel A, and only in its modes
    assign mode_on[0] = |shadow_a[7:6] && !(shadow_a[7:6] == 2'h1 && pwm && !a_tog);
    assign mode_on[1] = |shadow_a[5:4] && !(shadow_a[5:4] == 2'h1 && pwm);
    assign mode_on[2] = |shadow_a[3:2] && !(shadow_a[3:2] == 2'h1 && pwm);
    ////////////////////////////////////////////////////////////////////////////
    // shadows of control A and B; override judged only once the write has settled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shadow_a <= CTRL_A_RESET;
            shadow_b <= CTRL_B_RESET;
            since_wr <= 2'h3;
        end
        else if (wr_any)
        begin
            if (wr_ctrl)
                shadow_a <= reg_wdata[7:0];
            else
                shadow_b <= reg_wdata[7:0];
            since_wr <= 2'h0;
        end
        else if (since_wr != 2'h3)
        begin
            since_wr <= since_wr + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_override_on: assert property (since_wr >= 2'h2 |-> (port_override & mode_on) == mode_on)
        else $error("override missing for an enabled channel");
    a_override_off: assert property (since_wr >= 2'h2 |-> (port_override & ~mode_on) == 3'h0)
        else $error("override set for a disconnected channel");
    a_ctrl_readback: assert property (reg_rd && clk_en && reg_addr == REG_CTRL_A |=> reg_rdata == {8'h00, shadow_a})
        else $error("control A read differs from written value");
    a_ctrl_b_upper: assert property (reg_rd && clk_en && reg_addr == REG_CTRL_B |=> reg_rdata[15:8] == 8'h00)
        else $error("control B upper byte not zero");
    a_rdata_idle: assert property (!reg_rd && clk_en |=> reg_rdata == 16'h0000)
        else $error("read data present without a read");
    a_wave_by_tick: assert property (!$stable(wave_out) |->
        $past(timer_count_enable) || $past(timer_count_enable, 2) || $past(timer_count_enable, 3))
        else $error("waveform changed without a count tick");
    a_override_by_write: assert property (!$stable(port_override) |-> $past(wr_any) || $past(wr_any, 2))
        else $error("override changed without a control write");
    a_reset_quiet: assert property ($rose(rst_b) |-> wave_out == 3'h0 && port_override == 3'h0)
        else $error("outputs not idle after reset");
endmodule : cow_unit_chk

bind cow_unit cow_unit_chk chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .timer_count_enable(timer_count_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out(wave_out),
    .port_override(port_override));

// ===== test/tb_cow_unit.sv
// self-checking bench for the compare-output waveform unit
module tb_cow_unit
    import cow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic timer_count_enable = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [2:0] wave_out;
    logic [2:0] port_override;
    logic [15:0] rdv;
    int err_count = 0;
    int checked = 0;

    cow_unit dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .timer_count_enable(timer_count_enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wave_out(wave_out), .port_override(port_override));

    initial
    begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_is(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata & m;
        check(rdv, e);
    endtask : rd_is

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            timer_count_enable <= 1'b1;
            @(posedge clk);
            timer_count_enable <= 1'b0;
        end
    endtask : tick

    // three edges cover the combinational match and the single registered output stage
    task automatic wave_is(input logic [2:0] m, input logic [2:0] e);
        repeat (3) @(posedge clk);
        #1;
        check({13'h0000, wave_out & m}, {13'h0000, e});
    endtask : wave_is

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd_is(REG_CTRL_A, 16'h0000);
        rd_is(REG_CTRL_B, 16'h0000);
        check({13'h0000, port_override}, 16'h0000);
        $display("test reset_values done");
        // clear-on-match, top from compare A: toggle, clear, set
        wr(REG_CMP_A, 16'h0005);
        wr(REG_CMP_B, 16'h0002);
        wr(REG_CMP_C, 16'h0003);
        wr(REG_CTRL_B, 16'h0008);
        wr(REG_CTRL_A, 16'h006C);
        rd_is(REG_CTRL_A, 16'h006C);
        check({13'h0000, port_override}, 16'h0007);
        for (int i = 1; i <= 11; i++)
        begin
            tick(1);
            rd_is(REG_COUNT, 16'(i % 6));
            if (i == 5)
            begin
                wave_is(3'h7, 3'h4);
                wr(REG_CTRL_A, 16'h002C);
                wave_is(3'h7, 3'h4);
                check({13'h0000, port_override}, 16'h0006);
                wr(REG_CTRL_A, 16'h006C);
            end
        end
        wave_is(3'h7, 3'h5);
        $display("test non_pwm done");
        // single-slope, top from capture value 7
        wr(REG_COUNT, 16'h0000);
        wr(REG_CMP_A, 16'h0003);
        wr(REG_CAPTURE, 16'h0007);
        wr(REG_CTRL_B, 16'h0018);
        wr(REG_CTRL_A, 16'h0082);
        rd_is(REG_CTRL_B, 16'h0018);
        tick(8);
        wave_is(3'h1, 3'h1);
        tick(1);
        wr(REG_CMP_A, 16'h0005);
        tick(3);
        wave_is(3'h1, 3'h0);
        tick(4);
        wave_is(3'h1, 3'h1);
        tick(4);
        wave_is(3'h1, 3'h1);
        tick(2);
        wave_is(3'h1, 3'h0);
        wr(REG_CMP_A, 16'h0007);
        tick(10);
        wave_is(3'h1, 3'h1);
        $display("test fast_pwm done");
        // dual-slope with bottom update, top from capture value 6
        wr(REG_CTRL_A, 16'h0000);
        wr(REG_CTRL_B, 16'h0000);
        wr(REG_CMP_B, 16'h0002);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CAPTURE, 16'h0006);
        wr(REG_CTRL_B, 16'h0010);
        wr(REG_CTRL_A, 16'h0020);
        for (int i = 1; i <= 17; i++)
        begin
            tick(1);
            rd_is(REG_COUNT, 16'(i <= 6 ? i : (i <= 12 ? 12 - i : i - 12)));
            if (i == 7) wr(REG_CMP_B, 16'h0004);
            if (i == 9) wave_is(3'h2, 3'h0);
            if (i == 10) wr(REG_STATUS, 16'h0001);
            if (i == 10) rd_is(REG_STATUS, 16'h0000, 16'h0001);
            if (i == 11) wave_is(3'h2, 3'h2);
            if (i == 13) rd_is(REG_STATUS, 16'h0001, 16'h0001);
            if (i == 15) wave_is(3'h2, 3'h2);
            if (i == 17) wave_is(3'h2, 3'h0);
        end
        $display("test dual_slope done");
        report_and_stop();
    end

    initial
    begin
        #50000;
        err_count++;
        report_and_stop();
    end
endmodule : tb_cow_unit
